// ===== regbank_pkg.sv
package regbank_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 16;

    // address map
    localparam logic [15:0] MAP_LAST = 16'h0E3F;
    localparam logic [15:0] LIVE_LAST = 16'h0005;
    localparam logic [15:0] REV_ADDR = 16'h0002;
    localparam logic [15:0] DEVID_ADDR = 16'h0003;
    localparam logic [15:0] RB_SEL_ADDR = 16'h0004;
    localparam logic [15:0] UPD_ADDR = 16'h0005;
    localparam logic [15:0] S_FIRST = 16'h0100;
    localparam logic [15:0] S_LAST = 16'h0102;
    localparam logic [15:0] C_FIRST = 16'h0103;
    localparam logic [15:0] C_LAST = 16'h0108;
    localparam logic [15:0] ACLR_ADDR = 16'h0A00;
    localparam logic [15:0] STAT_FIRST = 16'h0D00;
    localparam logic [15:0] STAT_LAST = 16'h0D03;
    localparam logic [15:0] SEQ_FIRST = 16'h0E10;
    localparam logic [15:0] SEQ_LAST = 16'h0E3F;

    // storage slot layout
    localparam int SLOT_W = 7;
    localparam logic [6:0] IDX_S = 7'h06;
    localparam logic [6:0] IDX_C = 7'h09;
    localparam logic [6:0] IDX_STAT = 7'h0F;
    localparam logic [6:0] IDX_ACLR = 7'h13;
    localparam logic [6:0] IDX_SEQ = 7'h14;
    localparam int NSLOT = 68;
    localparam int NSTAT = 4;

    // field positions
    localparam int RB_SEL_BIT = 0;
    localparam int UPD_BIT = 0;
    localparam int ACLR_BIT = 0;

    // update clock divider
    localparam int SYS_DIV = 32;

    // buffered register reset values
    localparam logic [7:0] RST_S0 = 8'h18;
    localparam logic [7:0] RST_S1 = 8'h28;
    localparam logic [7:0] RST_S2 = 8'h45;
    localparam logic [7:0] RST_C0 = 8'h40;
    localparam logic [7:0] RST_C1 = 8'h42;
    localparam logic [7:0] RST_C2 = 8'h0F;
    localparam logic [7:0] RST_C3 = 8'h01;
    localparam logic [7:0] RST_ZERO = 8'h00;

    typedef struct packed {
        logic impl;
        logic ronly;
        logic sync_s;
        logic sync_c;
        logic stat;
        logic eexcl;
        logic [6:0] slot;
    } reg_class_type;

    // address to access class and storage slot
    function automatic reg_class_type decode(input logic [15:0] a);
        reg_class_type c;
        c = '0;
        if (a <= LIVE_LAST) begin
            c.impl = 1'b1;
            c.slot = a[6:0];
            c.ronly = (a == REV_ADDR) || (a == DEVID_ADDR);
            c.eexcl = 1'b1;
        end else if (a >= S_FIRST && a <= S_LAST) begin
            c.impl = 1'b1;
            c.sync_s = 1'b1;
            c.slot = 7'(IDX_S + 7'(a - S_FIRST));
        end else if (a >= C_FIRST && a <= C_LAST) begin
            c.impl = 1'b1;
            c.sync_c = 1'b1;
            c.slot = 7'(IDX_C + 7'(a - C_FIRST));
        end else if (a == ACLR_ADDR) begin
            c.impl = 1'b1;
            c.sync_s = 1'b1;
            c.eexcl = 1'b1;
            c.slot = IDX_ACLR;
        end else if (a >= STAT_FIRST && a <= STAT_LAST) begin
            c.impl = 1'b1;
            c.ronly = 1'b1;
            c.stat = 1'b1;
            c.slot = 7'(IDX_STAT + 7'(a - STAT_FIRST));
        end else if (a >= SEQ_FIRST && a <= SEQ_LAST) begin
            c.impl = 1'b1;
            c.eexcl = 1'b1;
            c.slot = 7'(IDX_SEQ + 7'(a - SEQ_FIRST));
        end
        return c;
    endfunction

endpackage

// ===== tick_div.sv
`timescale 1ns/1ps

// one-cycle enable every RATIO clocks
module tick_div #(
    parameter int RATIO = 32
) (
    input wire logic clk, // system clock
    input wire logic rst, // async reset, high
    output logic tick // one-cycle pulse
);
    logic [$clog2(RATIO)-1:0] cnt_r;

    // free-running count, wraps at ratio
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
            tick <= 1'b0;
        end else begin
            tick <= (cnt_r == ($clog2(RATIO))'(RATIO - 1));
            if (cnt_r == ($clog2(RATIO))'(RATIO - 1)) begin
                cnt_r <= '0;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

endmodule

// ===== buffered_register_bank.sv
// Behaviour
// - decode byte addresses 0x0000 to 0x0E3F, one byte each
// - multi-byte values: lsb at D0 of lowest address
// - eeprom sequence bytes 0x0E10-0x0E3F kept raw, no little-endian assembly
// - buffered writes reach functions only at an update event
// - update from bit 0 at 0x0005 or from update pin
// - directly wired buffered contents act at once
// - serial-class transfer timed by serial clock or pin
// - system-class transfer timed by system clock divided by 32
// - bit 0 at 0x0004 picks active (0) or buffered (1) readback
// - read-only active copy shows new data only after update
// - autoclear bit applied at update, cleared when action completes
// - strictest applicable access class wins
// - denied read returns zero, denied write ignored
// - unimplemented addresses behave like denied ones
// - eeprom controller owns registers exclusively while active
// - read-only registers always readable from serial port
// - eeprom-excluded registers never moved by eeprom controller
// - read-only registers never moved by eeprom controller
`timescale 1ns/1ps

module buffered_register_bank
    import regbank_pkg::*;
#(
    parameter logic [7:0] REV_ID = 8'h5A, // arbitrary revision code
    parameter logic [7:0] DEV_ID = 8'hA5, // arbitrary device code
    parameter int DIV_RATIO = regbank_pkg::SYS_DIV // update clock divide
) (
    input wire logic clk, // system clock, 10 MHz
    input wire logic rst, // async reset, high
    input wire logic ser_clk_tick, // serial clock edge enable
    input wire logic ser_req, // serial access strobe
    input wire logic ser_we, // serial write
    input wire logic [regbank_pkg::ADDR_W-1:0] ser_addr, // serial address
    input wire logic [regbank_pkg::DATA_W-1:0] ser_wdata, // serial write byte
    output logic ser_ack, // serial access done
    output logic ser_denied, // serial access refused
    output logic [regbank_pkg::DATA_W-1:0] ser_rdata, // serial read byte
    input wire logic ee_active, // eeprom load or store running
    input wire logic ee_req, // eeprom access strobe
    input wire logic ee_we, // eeprom write (load)
    input wire logic [regbank_pkg::ADDR_W-1:0] ee_addr, // eeprom address
    input wire logic [regbank_pkg::DATA_W-1:0] ee_wdata, // eeprom write byte
    output logic ee_ack, // eeprom access done
    output logic ee_denied, // eeprom access refused
    output logic [regbank_pkg::DATA_W-1:0] ee_rdata, // eeprom read byte
    input wire logic upd_pin, // multifunction pin level
    input wire logic upd_pin_en, // pin configured as update input
    input wire logic [8*regbank_pkg::NSTAT-1:0] status_in, // live status
    input wire logic action_done, // autoclear action finished
    output logic action_req, // active autoclear bit
    output logic [23:0] sysclk_ctrl, // active serial-class bytes
    output logic [7:0] direct_ctrl, // buffered byte, bypasses its active copy
    output logic [20:0] sysclk_period, // active period value
    output logic [19:0] stab_period // active stability value
);

    ////////////////////////////////////////////////////////////////////
    // storage

    logic [7:0] buf_r [NSLOT];
    logic [7:0] act_r [NSLOT];
    logic pend_s_r;
    logic pend_c_r;
    logic pin_q_r;
    logic div_tick;
    logic pin_evt;
    logic upd_evt;
    logic xfer_s;
    logic xfer_c;
    logic rb_sel;
    reg_class_type s_cls;
    reg_class_type e_cls;
    reg_class_type w_cls;
    logic ser_rd_ok;
    logic ser_wr_ok;
    logic ee_rd_ok;
    logic ee_wr_ok;
    logic w_en;
    logic [7:0] w_data;

    tick_div #(
        .RATIO(DIV_RATIO)
    ) u_div (
        .clk(clk),
        .rst(rst),
        .tick(div_tick)
    );

    // decode both sources; map limits live in the decoder
    assign s_cls = decode(ser_addr);
    assign e_cls = decode(ee_addr);
    assign rb_sel = buf_r[RB_SEL_ADDR[6:0]][RB_SEL_BIT];

    ////////////////////////////////////////////////////////////////////
    // access arbitration

    // strictest class wins: any refusing condition denies the access
    always_comb begin
        ser_rd_ok = s_cls.impl && (s_cls.ronly || !ee_active);
        ser_wr_ok = s_cls.impl && !s_cls.ronly && !ee_active;
        ee_rd_ok = ee_active && e_cls.impl && !e_cls.eexcl && !e_cls.ronly;
        ee_wr_ok = ee_rd_ok;
    end

    // single write port; the owner is fixed by ee_active so never both
    always_comb begin
        w_en = 1'b0;
        w_cls = s_cls;
        w_data = ser_wdata;
        if (ee_active) begin
            w_en = ee_req && ee_we && ee_wr_ok;
            w_cls = e_cls;
            w_data = ee_wdata;
        end else begin
            w_en = ser_req && ser_we && ser_wr_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // update events

    // pin is taken as synchronous; rising edge is the event
    assign pin_evt = upd_pin_en && upd_pin && !pin_q_r;
    assign upd_evt = pin_evt || (w_en && w_cls.slot == UPD_ADDR[6:0]
        && w_data[UPD_BIT]);
    // a pin event is its own timing reference for the serial class
    assign xfer_s = (pend_s_r && ser_clk_tick) || pin_evt;
    assign xfer_c = pend_c_r && div_tick;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_q_r <= 1'b0;
        end else begin
            pin_q_r <= upd_pin;
        end
    end

    // pending flags: a new event beats the clear of a finishing one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pend_s_r <= 1'b0;
            pend_c_r <= 1'b0;
        end else begin
            pend_s_r <= (pend_s_r && !xfer_s) || (upd_evt && !pin_evt);
            pend_c_r <= (pend_c_r && !xfer_c) || upd_evt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // buffered (and live) copy

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NSLOT; i++) begin
                buf_r[i] <= RST_ZERO;
            end
            buf_r[IDX_S] <= RST_S0;
            buf_r[IDX_S + 7'd1] <= RST_S1;
            buf_r[IDX_S + 7'd2] <= RST_S2;
            buf_r[IDX_C] <= RST_C0;
            buf_r[IDX_C + 7'd1] <= RST_C1;
            buf_r[IDX_C + 7'd2] <= RST_C2;
            buf_r[IDX_C + 7'd3] <= RST_C3;
        end else begin
            // autoclear also drops the request bit unless rewritten now
            if (action_done) begin
                buf_r[IDX_ACLR][ACLR_BIT] <= 1'b0;
            end
            // sequence bytes are stored as raw bytes, never reassembled
            if (w_en && w_cls.slot != UPD_ADDR[6:0]) begin
                buf_r[w_cls.slot] <= w_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // active copy

    // every pending byte of a class moves on the same enable
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NSLOT; i++) begin
                act_r[i] <= RST_ZERO;
            end
            act_r[IDX_S] <= RST_S0;
            act_r[IDX_S + 7'd1] <= RST_S1;
            act_r[IDX_S + 7'd2] <= RST_S2;
            act_r[IDX_C] <= RST_C0;
            act_r[IDX_C + 7'd1] <= RST_C1;
            act_r[IDX_C + 7'd2] <= RST_C2;
            act_r[IDX_C + 7'd3] <= RST_C3;
        end else begin
            if (action_done) begin
                act_r[IDX_ACLR][ACLR_BIT] <= 1'b0;
            end
            if (xfer_s) begin
                for (int i = 0; i < 3; i++) begin
                    act_r[IDX_S + 7'(i)] <= buf_r[IDX_S + 7'(i)];
                end
                act_r[IDX_ACLR] <= buf_r[IDX_ACLR];
                // status is frozen until an update captures it
                for (int i = 0; i < NSTAT; i++) begin
                    act_r[IDX_STAT + 7'(i)] <= status_in[8*i +: 8];
                end
            end
            if (xfer_c) begin
                for (int i = 0; i < 6; i++) begin
                    act_r[IDX_C + 7'(i)] <= buf_r[IDX_C + 7'(i)];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // readback

    // shared by both ports; refusal is applied by the caller
    function automatic logic [7:0] read_byte(input reg_class_type c);
        logic [7:0] v;
        v = act_r[c.slot];
        if (c.sync_s || c.sync_c) begin
            v = rb_sel ? buf_r[c.slot] : act_r[c.slot];
        end else if (!c.stat) begin
            v = buf_r[c.slot];
        end
        if (c.slot == REV_ADDR[6:0] && !c.sync_s && !c.sync_c && !c.stat) begin
            v = REV_ID;
        end
        if (c.slot == DEVID_ADDR[6:0] && c.ronly && !c.stat) begin
            v = DEV_ID;
        end
        if (c.slot == UPD_ADDR[6:0] && !c.sync_s && !c.sync_c && !c.stat) begin
            v = {7'h00, pend_s_r || pend_c_r};
        end
        return v;
    endfunction

    // serial answer one cycle after the strobe; refused reads give zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ser_ack <= 1'b0;
            ser_denied <= 1'b0;
            ser_rdata <= '0;
        end else begin
            ser_ack <= ser_req;
            ser_denied <= ser_req && (ser_we ? !ser_wr_ok : !ser_rd_ok);
            if (ser_req) begin
                ser_rdata <= (!ser_we && ser_rd_ok) ? read_byte(s_cls) : '0;
            end
        end
    end

    // eeprom answer, same timing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ee_ack <= 1'b0;
            ee_denied <= 1'b0;
            ee_rdata <= '0;
        end else begin
            ee_ack <= ee_req;
            ee_denied <= ee_req && !ee_rd_ok;
            if (ee_req) begin
                ee_rdata <= (!ee_we && ee_rd_ok) ? read_byte(e_cls) : '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // function outputs

    // multi-byte values assemble low address into low bits
    assign sysclk_ctrl = {act_r[IDX_S + 7'd2], act_r[IDX_S + 7'd1], act_r[IDX_S]};
    assign sysclk_period = {act_r[IDX_C + 7'd2][4:0], act_r[IDX_C + 7'd1],
        act_r[IDX_C]};
    assign stab_period = {act_r[IDX_C + 7'd5][3:0], act_r[IDX_C + 7'd4],
        act_r[IDX_C + 7'd3]};
    assign action_req = act_r[IDX_ACLR][ACLR_BIT];
    // wired straight from the buffered byte, so a write acts at once
    assign direct_ctrl = buf_r[IDX_S + 7'd2];

    ////////////////////////////////////////////////////////////////////
    // checks

    deny_zero_a: assert property (@(posedge clk) disable iff (rst)
        ser_ack && ser_denied |-> ser_rdata == 8'h00)
        else $error("denied serial read returned data");

    unmapped_deny_a: assert property (@(posedge clk) disable iff (rst)
        ser_req && !s_cls.impl |=> ser_ack && ser_denied && ser_rdata == 8'h00)
        else $error("unmapped access not refused");

    ee_owns_bus_a: assert property (@(posedge clk) disable iff (rst)
        ser_req && ee_active && !s_cls.ronly |=> ser_denied)
        else $error("serial access during eeprom activity");

    ronly_open_a: assert property (@(posedge clk) disable iff (rst)
        ser_req && !ser_we && s_cls.impl && s_cls.ronly |=> ser_ack && !ser_denied)
        else $error("read-only register refused");

    ee_exclude_a: assert property (@(posedge clk) disable iff (rst)
        ee_req && (e_cls.eexcl || e_cls.ronly) |=> ee_denied)
        else $error("eeprom reached excluded register");

    c_hold_a: assert property (@(posedge clk) disable iff (rst)
        !xfer_c |=> $stable(sysclk_period))
        else $error("system-class value moved without update");

    c_sync_a: assert property (@(posedge clk) disable iff (rst)
        !$stable(sysclk_period) |-> $past(div_tick))
        else $error("system-class transfer off divided clock");

    s_sync_a: assert property (@(posedge clk) disable iff (rst)
        !$stable(sysclk_ctrl) |-> $past(ser_clk_tick || pin_evt))
        else $error("serial-class transfer off serial clock");

    update_done_a: assert property (@(posedge clk) disable iff (rst)
        upd_evt |-> ##[1:70] !pend_c_r)
        else $error("system-class update not completed");

    readback_sel_a: assert property (@(posedge clk) disable iff (rst)
        ser_req && !ser_we && ser_rd_ok && s_cls.sync_c |=> ser_rdata ==
        $past(rb_sel ? buf_r[s_cls.slot] : act_r[s_cls.slot]))
        else $error("wrong copy read back");

    autoclear_a: assert property (@(posedge clk) disable iff (rst)
        action_done && !xfer_s |=> !action_req)
        else $error("autoclear bit not cleared");

    s_hold_a: assert property (@(posedge clk) disable iff (rst)
        !xfer_s |=> $stable(sysclk_ctrl))
        else $error("serial-class value moved without update");

    stat_freeze_a: assert property (@(posedge clk) disable iff (rst)
        !xfer_s |=> $stable(act_r[IDX_STAT]))
        else $error("status copy moved without update");

    ee_lockout_a: assert property (@(posedge clk) disable iff (rst)
        ser_req && ser_we && ee_active && !ee_req |=> $stable(direct_ctrl))
        else $error("serial write landed during eeprom activity");

endmodule

// ===== regbank_host.sv
`timescale 1ns/1ps

// host master for one access port; one byte per strobe
module regbank_host
    import regbank_pkg::*;
(
    input wire logic clk, // system clock
    output logic req, // access strobe
    output logic we, // write
    output logic [regbank_pkg::ADDR_W-1:0] addr, // byte address
    output logic [regbank_pkg::DATA_W-1:0] wdata, // write byte
    input wire logic ack, // access done
    input wire logic denied, // access refused
    input wire logic [regbank_pkg::DATA_W-1:0] rdata // read byte
);
    // idle lines start in a known state
    initial begin
        req = 1'b0;
        we = 1'b0;
        addr = '0;
        wdata = '0;
    end

    // address is built from two bytes, high byte first
    task automatic access(input logic w, input logic [7:0] hi, input logic [7:0] lo,
            input logic [7:0] d, output logic [7:0] rd, output logic den);
        int n;
        n = 0;
        @(posedge clk);
        req <= 1'b1;
        we <= w;
        addr <= {hi, lo};
        wdata <= d;
        @(posedge clk);
        req <= 1'b0;
        // released lines flip so a stale value never looks valid
        addr <= ~{hi, lo};
        wdata <= ~d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 4);
        rd = rdata;
        den = (ack === 1'b1) ? denied : 1'bx;
    endtask
endmodule

// ===== buffered_register_bank_test.sv
`timescale 1ns/1ps

module buffered_register_bank_test;
    import regbank_pkg::*;

    localparam int DIV = 4; // short update divider keeps waits brief
    localparam logic [7:0] REV = 8'h3C; // arbitrary revision code
    localparam logic [7:0] DEV = 8'hC3; // arbitrary device code
    localparam int LIMIT = 20000;
    localparam bit S = 1'b0;
    localparam bit E = 1'b1;
    localparam logic OK = 1'b0;
    localparam logic NO = 1'b1;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic tick = 1'b0;
    logic ee_active = 1'b0;
    logic upd_pin = 1'b0;
    logic upd_pin_en = 1'b0;
    logic [31:0] status_in = '0;
    logic action_done = 1'b0;
    logic s_req, s_we, s_ack, s_den, e_req, e_we, e_ack, e_den, action_req;
    logic [15:0] s_addr, e_addr;
    logic [7:0] s_wd, s_rd, e_wd, e_rd, direct_ctrl;
    logic [23:0] sysclk_ctrl;
    logic [20:0] sysclk_period;
    logic [19:0] stab_period;
    int fail_count = 0;
    int compares = 0;
    int cyc = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    always #50 clk = ~clk;

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            fail_count++;
            report_and_stop();
        end
    end

    buffered_register_bank #(.REV_ID(REV), .DEV_ID(DEV), .DIV_RATIO(DIV))
    u_buffered_register_bank (
        .clk(clk), .rst(rst), .ser_clk_tick(tick),
        .ser_req(s_req), .ser_we(s_we), .ser_addr(s_addr), .ser_wdata(s_wd),
        .ser_ack(s_ack), .ser_denied(s_den), .ser_rdata(s_rd),
        .ee_active(ee_active), .ee_req(e_req), .ee_we(e_we), .ee_addr(e_addr),
        .ee_wdata(e_wd), .ee_ack(e_ack), .ee_denied(e_den), .ee_rdata(e_rd),
        .upd_pin(upd_pin), .upd_pin_en(upd_pin_en), .status_in(status_in),
        .action_done(action_done), .action_req(action_req),
        .sysclk_ctrl(sysclk_ctrl), .direct_ctrl(direct_ctrl),
        .sysclk_period(sysclk_period), .stab_period(stab_period));

    regbank_host host_ser (.clk(clk), .req(s_req), .we(s_we), .addr(s_addr),
        .wdata(s_wd), .ack(s_ack), .denied(s_den), .rdata(s_rd));
    regbank_host host_ee (.clk(clk), .req(e_req), .we(e_we), .addr(e_addr),
        .wdata(e_wd), .ack(e_ack), .denied(e_den), .rdata(e_rd));

    ////////////////////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic report_and_stop();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one access on either port, judging data and refusal
    task automatic acc(input bit ee, input logic w, input logic [15:0] a,
            input logic [7:0] d, input logic [7:0] x, input logic xd);
        logic [7:0] r;
        logic dn;
        if (ee) begin
            host_ee.access(w, a[15:8], a[7:0], d, r, dn);
        end else begin
            host_ser.access(w, a[15:8], a[7:0], d, r, dn);
        end
        check(r, x);
        check(dn, xd);
    endtask

    task automatic wr(input bit ee, input logic [15:0] a, input logic [7:0] d, input logic xd);
        acc(ee, 1'b1, a, d, 8'h00, xd);
    endtask

    task automatic rd(input bit ee, input logic [15:0] a, input logic [7:0] x, input logic xd);
        acc(ee, 1'b0, a, 8'h00, x, xd);
    endtask

    task automatic pulse_tick();
        @(posedge clk);
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // system-class transfer lands on a divider tick, so allow one period plus two cycles
    task automatic wait_period(input logic [20:0] x);
        int n;
        n = 0;
        while (sysclk_period !== x && n < DIV + 2) begin
            @(posedge clk);
            n++;
        end
        check(sysclk_period, x);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        check(sysclk_ctrl, 24'h45_2818);
        check(direct_ctrl, 8'h45);
        check(sysclk_period, 21'h0F_4240);
        check(stab_period, 20'h0_0001);
        check(action_req, 1'b0);
        rd(S, 16'h0002, REV, OK);
        rd(S, 16'h0003, DEV, OK);
    endtask

    task automatic t_map();
        wr(S, 16'h0E3F, 8'hC7, OK);
        rd(S, 16'h0E3F, 8'hC7, OK);
        wr(S, 16'h0E40, 8'h99, NO);
        rd(S, 16'h0E40, 8'h00, NO);
        rd(S, 16'h0006, 8'h00, NO);
        wr(S, 16'h0002, 8'h11, NO);
        rd(S, 16'h0002, REV, OK);
    endtask

    task automatic t_sclass();
        wr(S, 16'h0100, 8'h5A, OK);
        wr(S, 16'h0102, 8'h77, OK);
        check(direct_ctrl, 8'h77);
        check(sysclk_ctrl, 24'h45_2818);
        wr(S, 16'h0004, 8'h00, OK);
        rd(S, 16'h0102, 8'h45, OK);
        wr(S, 16'h0004, 8'h01, OK);
        rd(S, 16'h0102, 8'h77, OK);
        wr(S, 16'h0005, 8'h01, OK);
        rd(S, 16'h0005, 8'h01, OK);
        check(sysclk_ctrl, 24'h45_2818);
        pulse_tick();
        check(sysclk_ctrl, 24'h77_285A);
        rd(S, 16'h0005, 8'h00, OK);
        wr(S, 16'h0004, 8'h00, OK);
        rd(S, 16'h0100, 8'h5A, OK);
    endtask

    task automatic t_cclass();
        wr(S, 16'h0103, 8'h11, OK);
        wr(S, 16'h0104, 8'h22, OK);
        wr(S, 16'h0105, 8'hF3, OK);
        wr(S, 16'h0106, 8'h9A, OK);
        check(sysclk_period, 21'h0F_4240);
        check(stab_period, 20'h0_0001);
        wr(S, 16'h0005, 8'h01, OK);
        wait_period(21'h13_2211);
        check(stab_period, 20'h0_009A);
    endtask

    // pin only counts while enabled as the update input
    task automatic t_pin();
        wr(S, 16'h0101, 8'h3E, OK);
        upd_pin <= 1'b1;
        repeat (3) @(posedge clk);
        check(sysclk_ctrl, 24'h77_285A);
        upd_pin <= 1'b0;
        upd_pin_en <= 1'b1;
        @(posedge clk);
        upd_pin <= 1'b1;
        repeat (3) @(posedge clk);
        check(sysclk_ctrl, 24'h77_3E5A);
        upd_pin <= 1'b0;
        upd_pin_en <= 1'b0;
    endtask

    task automatic t_status();
        status_in <= 32'h4433_2211;
        rd(S, 16'h0D01, 8'h00, OK);
        wr(S, 16'h0A00, 8'h01, OK);
        check(action_req, 1'b0);
        wr(S, 16'h0005, 8'h01, OK);
        pulse_tick();
        check(action_req, 1'b1);
        rd(S, 16'h0D01, 8'h22, OK);
        rd(S, 16'h0D03, 8'h44, OK);
        action_done <= 1'b1;
        @(posedge clk);
        action_done <= 1'b0;
        repeat (2) @(posedge clk);
        check(action_req, 1'b0);
    endtask

    task automatic t_eeprom();
        ee_active <= 1'b1;
        wr(S, 16'h0101, 8'h99, NO);
        rd(S, 16'h0101, 8'h00, NO);
        rd(S, 16'h0003, DEV, OK);
        wr(S, 16'h0102, 8'h99, NO);
        check(direct_ctrl, 8'h77);
        wr(E, 16'h0101, 8'h6C, OK);
        rd(E, 16'h0D00, 8'h00, NO);
        rd(E, 16'h0002, 8'h00, NO);
        wr(E, 16'h0004, 8'h01, NO);
        rd(E, 16'h0E10, 8'h00, NO);
        wr(E, 16'h0A00, 8'h01, NO);
        ee_active <= 1'b0;
        rd(E, 16'h0101, 8'h00, NO);
        rd(S, 16'h0101, 8'h3E, OK);
        wr(S, 16'h0004, 8'h01, OK);
        rd(S, 16'h0101, 8'h6C, OK);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_map();
        t_sclass();
        t_cclass();
        t_pin();
        t_status();
        t_eeprom();
        report_and_stop();
    end
endmodule
